// ### sic_cpu_model.sv
// cpu interrupt controller stand-in: enters the service routine of a request
// assumes irq_i level and mask_i global mask on the same clock
`timescale 1ns/1ps
module sic_cpu_model
(
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire irq_i,
    input wire mask_i,
    output reg ack_o
);
    reg [1:0] cnt;
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt <= 2'h0;
            ack_o <= 1'b0;
        end
        else
        begin
            ack_o <= (cnt == 2'h2);
            cnt <= (irq_i && !mask_i && cnt != 2'h3) ? cnt + 2'h1 : 2'h0;
        end
    end
endmodule // sic_cpu_model

// ### sic_integrity_ctrl.v
// system integrity control/status logic: supply warning, clock guard and reset-source flags
// assumes comparator, clock-loss and reset-cause inputs are asynchronous to ref_clk_i
`timescale 1ns/1ps
`include "sic_regs.vh"

module sic_integrity_ctrl
(
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire [`SIC_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    output reg avs_response_err_o,
    input wire supply_warn_comp_i,
    input wire main_clk_lost_i,
    input wire lvd_option_en_i,
    input wire clock_guard_option_en_i,
    input wire lv_reset_event_i,
    input wire wdg_reset_event_i,
    input wire cpu_irq_masked_i,
    input wire supply_warn_irq_ack_i,
    input wire halt_exit_by_reset_i,
    output reg irq_o,
    output reg backup_osc_select_o,
    output reg clock_guard_enable_o,
    output reg halt_active_o
);

    // ****************************************
    // input synchronisers
    // ****************************************
    wire comp_s;
    wire lost_s;
    wire lvd_opt;
    wire cg_opt;
    wire lvr_s;
    wire wdr_s;
    wire hrst_s;

    sic_sync2 u_sync_comp
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(supply_warn_comp_i),
        .sync_o(comp_s)
    );

    sic_sync2 u_sync_lost
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(main_clk_lost_i),
        .sync_o(lost_s)
    );

    sic_sync2 u_sync_lvd_opt
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(lvd_option_en_i),
        .sync_o(lvd_opt)
    );

    sic_sync2 u_sync_cg_opt
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(clock_guard_option_en_i),
        .sync_o(cg_opt)
    );

    sic_sync2 u_sync_lvr
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(lv_reset_event_i),
        .sync_o(lvr_s)
    );

    sic_sync2 u_sync_wdr
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(wdg_reset_event_i),
        .sync_o(wdr_s)
    );

    sic_sync2 u_sync_hrst
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(halt_exit_by_reset_i),
        .sync_o(hrst_s)
    );

    // ****************************************
    // bus decode
    // ****************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;
    reg [1:0] state;
    wire req = (avs_read_i | avs_write_i) & (state == ST_IDLE);
    wire hit_cs = (avs_address_i == `SIC_OFS_CTRL_STATUS);
    wire hit_ctl = (avs_address_i == `SIC_OFS_CONTROL);
    wire wr_cs = req & avs_write_i & hit_cs & avs_byteenable_i[0];
    wire wr_ctl = req & avs_write_i & hit_ctl & avs_byteenable_i[0];
    wire rd_cs = req & avs_read_i & hit_cs;

    // ****************************************
    // registers and flags
    // ****************************************
    reg sw_ie;
    reg cg_ie;
    reg cg_det;
    reg lv_rf;
    reg wdg_rf;
    reg sw_flag_q;
    reg sw_pend;
    reg halt;
    reg wait_mode;
    reg cg_ie_saved;
    reg backup;
    wire sw_active = lvd_opt;
    wire sw_flag = sw_active & comp_s;
    wire cg_run = cg_opt & ~halt;
    wire cg_det_rd = cg_opt & cg_det;
    wire [7:0] cs_val = {1'b0, sw_ie, sw_flag, lv_rf, 1'b0, cg_ie, cg_det_rd, wdg_rf};

    // ****************************************
    // control bits and halt
    // ****************************************
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sw_ie <= 1'b0;
            cg_ie <= 1'b0;
            halt <= 1'b0;
            wait_mode <= 1'b0;
            cg_ie_saved <= 1'b0;
        end
        else
        begin
            // writes to bit 3 ignored, software keeps it zero
            if (wr_cs)
            begin
                sw_ie <= avs_writedata_i[`SIC_BIT_SW_IE];
                cg_ie <= avs_writedata_i[`SIC_BIT_CG_IE];
            end
            // wait has no effect on this block
            if (wr_ctl)
                wait_mode <= avs_writedata_i[`SIC_BIT_WAIT];
            if (wr_ctl & avs_writedata_i[`SIC_BIT_HALT] & ~halt)
            begin
                halt <= 1'b1;
                cg_ie_saved <= cg_ie;
            end
            else if (halt & hrst_s)
            begin
                halt <= 1'b0;
                sw_ie <= 1'b0;
                cg_ie <= 1'b0;
            end
            else if (wr_ctl & ~avs_writedata_i[`SIC_BIT_HALT] & halt)
            begin
                halt <= 1'b0;
                cg_ie <= cg_ie_saved;
            end
        end
    end

    // ****************************************
    // clock guard detection
    // ****************************************
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cg_det <= 1'b0;
            backup <= 1'b0;
        end
        else
        begin
            // backup clock follows loss while guard runs
            backup <= cg_run & lost_s;
            // set wins over read clear; read clear only once recovered
            if (cg_run & lost_s)
                cg_det <= 1'b1;
            else if ((halt & hrst_s) | (rd_cs & ~lost_s))
                cg_det <= 1'b0;
        end
    end

    // ****************************************
    // supply warning request
    // ****************************************
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            sw_flag_q <= 1'b0;
            sw_pend <= 1'b0;
        end
        else
        begin
            sw_flag_q <= sw_flag;
            // toggle in either direction requests, service entry clears
            if (sw_ie & sw_active & (sw_flag != sw_flag_q))
                sw_pend <= 1'b1;
            else if (supply_warn_irq_ack_i)
                sw_pend <= 1'b0;
        end
    end

    // reset-source flags survive the block reset; only their events and writes move them
    always @(posedge ref_clk_i)
    begin
        if (lvr_s)
        begin
            lv_rf <= 1'b1;
            wdg_rf <= 1'b0;
        end
        else
        begin
            // pin or watchdog reset leave lv_rf alone
            if (wr_cs & ~avs_writedata_i[`SIC_BIT_LV_RF])
                lv_rf <= 1'b0;
            if (wdr_s)
                wdg_rf <= 1'b1;
            else if (wr_cs & ~avs_writedata_i[`SIC_BIT_WDG_RF])
                wdg_rf <= 1'b0;
        end
    end
    // wdg_rf meaningful only with low voltage option

    // ****************************************
    // interrupt request and outputs
    // ****************************************
    wire cg_req = cg_ie & cg_opt & cg_det;
    wire irq_next = ~cpu_irq_masked_i & (sw_pend | cg_req);
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            irq_o <= 1'b0;
            backup_osc_select_o <= 1'b0;
            clock_guard_enable_o <= 1'b0;
            halt_active_o <= 1'b0;
        end
        else
        begin
            irq_o <= irq_next;
            backup_osc_select_o <= backup;
            clock_guard_enable_o <= cg_run;
            halt_active_o <= halt;
        end
    end

    // ****************************************
    // bus handshake: one wait cycle, answer stands one cycle
    // ****************************************
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= ST_IDLE;
            avs_readdata_o <= 32'h00000000;
            avs_waitrequest_o <= 1'b1;
            avs_response_err_o <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (req)
                    begin
                        state <= ST_DONE;
                        avs_waitrequest_o <= 1'b0;
                        avs_response_err_o <= ~(hit_cs | hit_ctl);
                        if (avs_read_i & hit_cs)
                            avs_readdata_o <= {24'h000000, cs_val};
                        else if (avs_read_i & hit_ctl)
                            avs_readdata_o <= {30'h00000000, wait_mode, halt};
                        else
                            avs_readdata_o <= 32'h00000000;
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                    avs_response_err_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // sic_integrity_ctrl

// ****************************************
// two-flop synchroniser
// ****************************************
module sic_sync2
#(
    parameter RESET_VAL = 1'b0
)
(
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire async_i,
    output wire sync_o
);

    reg [1:0] stages;

    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            stages <= {2{RESET_VAL}};
        end
        else
        begin
            stages <= {stages[0], async_i};
        end
    end

    assign sync_o = stages[1];

endmodule // sic_sync2

// ### sic_integrity_ctrl_assertions.sv
// port-level checks of the system integrity control block
// assumes binding to sic_integrity_ctrl, one clock domain
`timescale 1ns/1ps
`include "sic_regs.vh"
module sic_chk
(
    input wire ref_clk_i,
    input wire arst_n_i,
    input wire [`SIC_ADDR_W-1:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire avs_response_err_o,
    input wire main_clk_lost_i,
    input wire clock_guard_option_en_i,
    input wire cpu_irq_masked_i,
    input wire irq_o,
    input wire backup_osc_select_o,
    input wire clock_guard_enable_o,
    input wire halt_active_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_take;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_rd0;
        !avs_waitrequest_o && avs_read_i && avs_address_i == `SIC_OFS_CTRL_STATUS;
    endsequence
    property p_ans;
        s_take |=> !avs_waitrequest_o;
    endproperty
    a_ans: assert property (p_ans) else $error("answer late");
    property p_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_one: assert property (p_one) else $error("answer too long");
    property p_err;
        !avs_waitrequest_o |-> avs_response_err_o == (avs_address_i != 4'h0 && avs_address_i != 4'h4);
    endproperty
    a_err: assert property (p_err) else $error("wrong error response");
    property p_rsv;
        s_rd0 |-> avs_readdata_o[31:8] == 24'h0 && !avs_readdata_o[3];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_cg0;
        !clock_guard_option_en_i [*4] ##1 s_rd0 |-> !avs_readdata_o[1];
    endproperty
    a_cg0: assert property (p_cg0) else $error("detect flag with guard off");
    property p_mask;
        cpu_irq_masked_i [*2] |-> !irq_o;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked");
    property p_halt;
        halt_active_o && $past(halt_active_o) |-> !clock_guard_enable_o && !backup_osc_select_o;
    endproperty
    a_halt: assert property (p_halt) else $error("guard on in halt");
    property p_back;
        !main_clk_lost_i [*6] |-> !backup_osc_select_o;
    endproperty
    a_back: assert property (p_back) else $error("backup clock kept");
endmodule // sic_chk
bind sic_integrity_ctrl sic_chk u_chk(.ref_clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_readdata_o, .avs_waitrequest_o, .avs_response_err_o, .main_clk_lost_i, .clock_guard_option_en_i,
    .cpu_irq_masked_i, .irq_o, .backup_osc_select_o, .clock_guard_enable_o, .halt_active_o);

// ### sic_regs.vh
// register offset, field positions, reset values and timing for the system integrity control block
// assumes a byte-wide register on a 32-bit avalon-mm word
`ifndef SIC_REGS_VH
`define SIC_REGS_VH

`define SIC_ADDR_W 4
`define SIC_OFS_CTRL_STATUS 4'h0
`define SIC_OFS_CONTROL 4'h4
`define SIC_BIT_WDG_RF 0
`define SIC_BIT_CG_DET 1
`define SIC_BIT_CG_IE 2
`define SIC_BIT_LV_RF 4
`define SIC_BIT_SW_FLAG 5
`define SIC_BIT_SW_IE 6
`define SIC_BIT_HALT 0
`define SIC_BIT_WAIT 1
`define SIC_CTRL_RESET 8'h00
`define SIC_CLK_PERIOD_PS 4000
`define SIC_READ_LAT_NS 4
`define SIC_READ_LAT_CYC ((`SIC_READ_LAT_NS * 1000 + `SIC_CLK_PERIOD_PS - 1) / `SIC_CLK_PERIOD_PS)

`endif

// ### test_system_integrity_status_ctrl.sv
// self-checking bench of the system integrity control block
// assumes the cpu stand-in model and the bound checker
`timescale 1ns/1ps
module test_system_integrity_status_ctrl;
    reg ref_clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg [3:0] adr = 4'h0;
    reg rd = 1'b0, wr = 1'b0, comp = 1'b0, lost = 1'b0, cgo = 1'b1, lvr = 1'b0, wdr = 1'b0, msk = 1'b1, hxr = 1'b0;
    reg [31:0] wd = 32'h0;
    reg [31:0] got;
    reg gerr;
    reg [7:0] exp;
    wire [31:0] rdata;
    wire wrq, err, irq, bko, cge, hlt, ack;
    integer err_count = 0, samples_checked = 0, cyc = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    sic_integrity_ctrl uut(.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wrq), .avs_response_err_o(err), .supply_warn_comp_i(comp), .main_clk_lost_i(lost),
        .lvd_option_en_i(1'b1), .clock_guard_option_en_i(cgo), .lv_reset_event_i(lvr), .wdg_reset_event_i(wdr),
        .cpu_irq_masked_i(msk), .supply_warn_irq_ack_i(ack), .halt_exit_by_reset_i(hxr), .irq_o(irq),
        .backup_osc_select_o(bko), .clock_guard_enable_o(cge), .halt_active_o(hlt));
    sic_cpu_model cpu(.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .irq_i(irq), .mask_i(msk), .ack_o(ack));
    task complete_run;
    begin
        $display("compares %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask
    task chk(input [31:0] seen, input [31:0] want);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== want)
        begin
            err_count = err_count + 1;
            $display("mismatch at %0t saw %h expected %h", $time, seen, want);
        end
    end
    endtask
    always @(posedge ref_clk_i)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            complete_run;
        end
    end
    task bus(input w, input [3:0] a, input [7:0] d);
    begin
        @(posedge ref_clk_i);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h0, d};
        @(posedge ref_clk_i);
        while (wrq !== 1'b0)
            @(posedge ref_clk_i);
        got = rdata;
        gerr = err;
        rd <= 1'b0;
        wr <= 1'b0;
    end
    endtask
    task rc(input [7:0] e);
    begin
        bus(0, 4'h0, 8'h00);
        chk(got, {24'h0, e});
    end
    endtask
    task ev(input l);
    begin
        @(posedge ref_clk_i);
        lvr <= l;
        wdr <= !l;
        repeat (4) @(posedge ref_clk_i);
        lvr <= 1'b0;
        wdr <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    end
    endtask
    task pause(input integer n);
    begin
        repeat (n) @(posedge ref_clk_i);
    end
    endtask
    initial
    begin
        got = $urandom(32'he9a6);
        pause(4);
        arst_n_i <= 1'b1;
        bus(1, 4'h0, 8'h00);
        rc(8'h00);
        ev(0);
        rc(8'h01);
        ev(1);
        rc(8'h10);
        ev(0);
        rc(8'h11);
        bus(1, 4'h0, 8'h00);
        rc(8'h00);
        repeat (3)
        begin
            exp = $urandom;
            exp = exp & 8'h44;
            bus(1, 4'h0, exp);
            rc(exp);
        end
        bus(1, 4'h4, 8'h02);
        bus(1, 4'h0, 8'h40);
        comp <= 1'b1;
        pause(8);
        rc(8'h60);
        chk(irq, 1'b0);
        msk <= 1'b0;
        pause(2);
        chk(irq, 1'b1);
        pause(8);
        chk(irq, 1'b0);
        comp <= 1'b0;
        pause(12);
        rc(8'h40);
        bus(1, 4'h0, 8'h04);
        lost <= 1'b1;
        pause(8);
        chk(bko, 1'b1);
        rc(8'h06);
        rc(8'h06);
        chk(irq, 1'b1);
        lost <= 1'b0;
        pause(8);
        chk(bko, 1'b0);
        bus(0, 4'h0, 8'h00);
        rc(8'h04);
        cgo <= 1'b0;
        lost <= 1'b1;
        pause(8);
        rc(8'h04);
        chk(irq, 1'b0);
        lost <= 1'b0;
        pause(8);
        cgo <= 1'b1;
        pause(8);
        chk(cge, 1'b1);
        bus(1, 4'h4, 8'h01);
        lost <= 1'b1;
        pause(8);
        chk({hlt, cge, bko}, 3'h4);
        lost <= 1'b0;
        pause(8);
        bus(1, 4'h4, 8'h00);
        pause(3);
        chk({hlt, cge}, 2'h1);
        rc(8'h04);
        bus(1, 4'h4, 8'h01);
        hxr <= 1'b1;
        pause(6);
        hxr <= 1'b0;
        pause(6);
        rc(8'h00);
        bus(0, 4'h8, 8'h00);
        chk({gerr, got}, {1'b1, 32'h0});
        complete_run;
    end
endmodule // test_system_integrity_status_ctrl
